// ---- rtl/channel_sequence_select.sv ----
// Channel mask capture, ascending conversion sequencing and result coding for a four-channel converter.
// Functional notes
// R1 - Selected channels convert in ascending channel order.
// R2 - Source select picks pins or mask register.
// R3 - Mask bit high at start includes channel.
// R4 - Mask latched at start, held through sequence.
// R5 - Bus bits 0..3 map channels 1..4.
// R6 - Data lines are inputs during write window.
// R7 - Mask register loads on write strobe rise.
// R8 - Mask register keeps contents until rewritten.
// R9 - Software mode: pin1 clock, pin2 clock select.
// R10 - Software mode: pins 3, 4 ignored.
// R11 - Results are 14-bit, span over 16384.
// R12 - Bipolar variants code in two's complement.
// R13 - Unipolar variants code in straight binary.
// R14 - Code transitions fall at half steps.
// R15 - Busy rises at start, falls after last.
// R16 - Fixed time per channel, end pulse each.
// R17 - Clock select high uses external clock.
`timescale 1ns/1ps
`include "channel_sequence_select_params.svh"

module channel_sequence_select #(
  parameter bit BIPOLAR = 1'b1,
  parameter int CONV_CYCLES = `CSS_CONV_CYCLES,
  parameter int EXT_CONV_EDGES = `CSS_EXT_CONV_EDGES,
  parameter int EOC_CYCLES = `CSS_EOC_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic conversionStart_n,
  input wire logic softwareSelect,
  input wire logic [3:0] hwChannelPins,
  input wire channel_sequence_select_pkg::hostBus_type hostBus,
  input wire logic [`CSS_CHANNELS*`CSS_LEVEL_BITS-1:0] trackLevels,
  output logic [3:0] busBitsOut,
  output logic [3:0] busBitsOe,
  output logic busy,
  output logic endOfConversion_n,
  output logic holdActive,
  output logic resultValid,
  output channel_sequence_select_pkg::result_type result,
  output logic [3:0] activeMask,
  output logic [3:0] channelMask,
  output logic externalClockInUse
);
  import channel_sequence_select_pkg::*;

  // Lowest set bit of a mask, which is the next channel in ascending order.
  function automatic logic [1:0] lowestChannel(input logic [3:0] mask);
    lowestChannel = 2'h0;
    for (int i = `CSS_CHANNELS - 1; i >= 0; i--) begin
      if (mask[i]) begin
        lowestChannel = i[1:0];
      end
    end
  endfunction

  // Every pin input passes two flip-flops; only the second stage feeds logic.
  logic [12:0] pinMeta;
  logic [12:0] pinSync;
  always_ff @(posedge clk) begin
    if (srst) begin
      pinMeta <= 13'h1fff;
      pinSync <= 13'h1fff;
    end else begin
      pinMeta <= {conversionStart_n, softwareSelect, hwChannelPins, hostBus.chipSelect_n, hostBus.readStrobe_n,
                  hostBus.writeStrobe_n, hostBus.busBits};
      pinSync <= pinMeta;
    end
  end

  logic startSync_n;
  logic swSelSync;
  logic [3:0] hwPinSync;
  hostBus_type busSync;
  assign startSync_n = pinSync[12];
  assign swSelSync = pinSync[11];
  assign hwPinSync = pinSync[10:7];
  assign busSync = pinSync[6:0];

  // Previous-cycle copies used for edge detection and for the data seen while the strobe was low.
  logic startPrev_n;
  logic extClkPrev;
  hostBus_type busPrev;
  always_ff @(posedge clk) begin
    if (srst) begin
      startPrev_n <= 1'b1;
      extClkPrev <= 1'b1; // Matches the synchroniser's idle level, so no false tick follows reset.
      busPrev <= 7'h7f;
    end else begin
      startPrev_n <= startSync_n;
      extClkPrev <= hwPinSync[`CSS_PIN_EXT_CLK];
      busPrev <= busSync;
    end
  end

  logic startRise;
  logic writeWindowPrev;
  logic writeCapture;
  assign startRise = ~startPrev_n & startSync_n;
  // The write window is open while chip select and the write strobe are low and the read strobe is high; the data lines are never driven.
  assign writeWindowPrev = ~busPrev.chipSelect_n & busPrev.readStrobe_n & ~busPrev.writeStrobe_n; // R6
  assign writeCapture = writeWindowPrev & busSync.writeStrobe_n; // R7

  // Mask register: loaded only by a completed write, untouched by conversions.
  always_ff @(posedge clk) begin
    if (srst) begin
      channelMask <= `CSS_MASK_RESET;
    end else if (writeCapture) begin
      channelMask <= busPrev.busBits; // R5 R7 R8
    end
  end

  // The sequencer never drives the data lines; result readout lives elsewhere.
  always_ff @(posedge clk) begin
    if (srst) begin
      busBitsOut <= 4'h0;
      busBitsOe <= 4'h0;
    end else begin
      busBitsOut <= 4'h0;
      busBitsOe <= 4'h0; // R6
    end
  end

  // Pin 2 only picks the clock source in software mode; pins 3 and 4 are ignored there.
  logic useExternal;
  logic extTick;
  logic [3:0] sourceMask;
  assign useExternal = swSelSync & hwPinSync[`CSS_PIN_CLK_SEL]; // R9 R17
  assign extTick = hwPinSync[`CSS_PIN_EXT_CLK] & ~extClkPrev; // R9
  assign sourceMask = swSelSync ? channelMask : hwPinSync; // R2 R10

  always_ff @(posedge clk) begin
    if (srst) begin
      externalClockInUse <= 1'b0;
    end else if (startRise) begin
      externalClockInUse <= useExternal; // R17
    end
  end

  // Sequencer state.
  seqState_type state;
  logic [3:0] pending;
  logic [1:0] channel;
  logic [7:0] cycleCount;
  logic [7:0] edgeCount;
  logic [7:0] eocCount;
  logic [`CSS_CHANNELS*`CSS_LEVEL_BITS-1:0] heldLevels;
  logic convDone;
  logic [3:0] remaining;

  // A conversion ends after a fixed count of internal cycles or of external clock edges.
  assign convDone = externalClockInUse ? (extTick && edgeCount == 8'(EXT_CONV_EDGES - 1)) :
                    (cycleCount == 8'(CONV_CYCLES - 1)); // R16
  assign remaining = pending & ~(4'h1 << channel);

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SEQ_IDLE;
      pending <= 4'h0;
      channel <= 2'h0;
      activeMask <= 4'h0;
      busy <= 1'b0;
      holdActive <= 1'b0;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (startRise) begin
            activeMask <= sourceMask; // R3 R4
            pending <= sourceMask; // R4
            channel <= lowestChannel(sourceMask); // R1
            busy <= 1'b1; // R15
            holdActive <= 1'b1;
            // An empty mask still shows one busy cycle and then returns to tracking.
            state <= (sourceMask == 4'h0) ? SEQ_EOC : SEQ_CONVERT;
          end
        end
        SEQ_CONVERT: begin
          if (convDone) begin
            pending <= remaining;
            state <= SEQ_EOC;
          end
        end
        SEQ_EOC: begin
          if (eocCount == 8'h00) begin
            if (pending == 4'h0) begin
              busy <= 1'b0; // R15
              holdActive <= 1'b0;
              state <= SEQ_IDLE;
            end else begin
              channel <= lowestChannel(pending); // R1
              state <= SEQ_CONVERT;
            end
          end
        end
        default: begin
          state <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Per-channel timers restart on every new channel.
  always_ff @(posedge clk) begin
    if (srst) begin
      cycleCount <= 8'h00;
      edgeCount <= 8'h00;
    end else if (state != SEQ_CONVERT || convDone) begin
      cycleCount <= 8'h00;
      edgeCount <= 8'h00;
    end else begin
      cycleCount <= cycleCount + 8'h01;
      if (extTick) begin
        edgeCount <= edgeCount + 8'h01;
      end
    end
  end

  // Track/holds go into hold at the start edge, so the levels are frozen for the whole sequence.
  always_ff @(posedge clk) begin
    if (srst) begin
      heldLevels <= '0;
    end else if (state == SEQ_IDLE && startRise) begin
      heldLevels <= trackLevels;
    end
  end

  logic [`CSS_CODE_BITS-1:0] nextCode;
  result_coder #(
    .BIPOLAR(BIPOLAR)
  ) coder (
    .heldLevel(heldLevels[channel*`CSS_LEVEL_BITS +: `CSS_LEVEL_BITS]),
    .code(nextCode)
  );

  // End-of-conversion pulse and result latch, one per converted channel.
  always_ff @(posedge clk) begin
    if (srst) begin
      endOfConversion_n <= 1'b1;
      eocCount <= 8'h00;
      resultValid <= 1'b0;
      result <= '0;
    end else begin
      resultValid <= 1'b0;
      if (state == SEQ_CONVERT && convDone) begin
        endOfConversion_n <= 1'b0; // R16
        eocCount <= 8'(EOC_CYCLES - 1);
        resultValid <= 1'b1;
        result <= '{code: nextCode, channel: channel}; // R11
      end else if (state == SEQ_EOC) begin
        if (eocCount == 8'h00) begin
          endOfConversion_n <= 1'b1;
        end else begin
          eocCount <= eocCount - 8'h01;
        end
      end
    end
  end

endmodule // channel_sequence_select

// ---- rtl/channel_sequence_select_params.svh ----
// Offsets, reset values, field positions and timing counts for the channel sequencer.
`ifndef CHANNEL_SEQUENCE_SELECT_PARAMS_SVH
`define CHANNEL_SEQUENCE_SELECT_PARAMS_SVH

`define CSS_CHANNELS 4
`define CSS_CODE_BITS 14
`define CSS_LEVEL_BITS 15
`define CSS_CODE_MAX 14'h3fff
`define CSS_MASK_RESET 4'h0
`define CSS_CLK_PERIOD_NS 20
`define CSS_CONV_TIME_NS 2400
`define CSS_CONV_CYCLES ((`CSS_CONV_TIME_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS)
`define CSS_EXT_CONV_EDGES 16
`define CSS_EOC_CYCLES 1
`define CSS_PIN_EXT_CLK 0
`define CSS_PIN_CLK_SEL 1

`endif

// ---- rtl/channel_sequence_select_pkg.sv ----
// Types shared by the channel sequencer and its result coder.
package channel_sequence_select_pkg;

  // Host strobes and the four low data lines as seen at the pins.
  typedef struct packed {
    logic chipSelect_n;
    logic readStrobe_n;
    logic writeStrobe_n;
    logic [3:0] busBits;
  } hostBus_type;

  // One finished conversion result.
  typedef struct packed {
    logic [13:0] code;
    logic [1:0] channel;
  } result_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CONVERT,
    SEQ_EOC
  } seqState_type;

endpackage

// ---- rtl/result_coder.sv ----
// Turns a held level in half-step units into a 14-bit result code.
`timescale 1ns/1ps
`include "channel_sequence_select_params.svh"

module result_coder #(
  parameter bit BIPOLAR = 1'b1
) (
  input wire logic [`CSS_LEVEL_BITS-1:0] heldLevel,
  output logic [`CSS_CODE_BITS-1:0] code
);
  import channel_sequence_select_pkg::*;

  logic [`CSS_LEVEL_BITS:0] rounded;
  logic [`CSS_CODE_BITS-1:0] straight;

  // Adding one half step before halving puts every transition midway between whole steps.
  always_comb begin
    rounded = {1'b0, heldLevel} + 16'h0001; // R14
    if (rounded[`CSS_LEVEL_BITS:1] > {1'b0, `CSS_CODE_MAX}) begin
      straight = `CSS_CODE_MAX; // R11
    end else begin
      straight = rounded[`CSS_CODE_BITS:1]; // R11
    end
  end

  // Flipping the top bit turns offset binary into two's complement, so midscale reads zero.
  always_comb begin
    if (BIPOLAR) begin
      code = {~straight[`CSS_CODE_BITS-1], straight[`CSS_CODE_BITS-2:0]}; // R12
    end else begin
      code = straight; // R13
    end
  end

endmodule // result_coder

// ---- tb/channel_sequence_select_sva.sv ----
// Port assertions for the channel sequencer.
`timescale 1ns/1ps
module channel_sequence_select_sva #(
  parameter int CONV_CYCLES = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic busy,
  input wire logic endOfConversion_n,
  input wire logic holdActive,
  input wire logic resultValid,
  input wire channel_sequence_select_pkg::result_type result,
  input wire logic [3:0] activeMask,
  input wire logic [3:0] busBitsOe,
  input wire logic externalClockInUse
);
  import channel_sequence_select_pkg::*;
  logic [1:0] lastCh;
  logic gotOne;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Last channel reported in this run; cleared while idle so runs do not mix.
  always_ff @(posedge clk) begin
    if (srst || !busy) begin
      gotOne <= 1'b0;
      lastCh <= 2'h0;
    end else if (resultValid) begin
      gotOne <= 1'b1;
      lastCh <= result.channel;
    end
  end
  sequence sStart;
    $rose(busy) && activeMask != 4'h0 && !externalClockInUse;
  endsequence
  sequence sFirstEnd;
    resultValid && !endOfConversion_n;
  endsequence
  AST_FIRST_TIME: assert property (sStart |-> ##CONV_CYCLES sFirstEnd)
    else $error("first result late or early");
  AST_EOC_PULSE: assert property ($fell(endOfConversion_n) |-> resultValid ##1 endOfConversion_n)
    else $error("end pulse malformed");
  AST_EMPTY_RUN: assert property ($rose(busy) && activeMask == 4'h0 |=> !busy && endOfConversion_n)
    else $error("empty run wrong length");
  AST_ASCENDING: assert property (resultValid && gotOne |-> result.channel > lastCh)
    else $error("channels out of order");
  AST_IN_MASK: assert property (resultValid |-> activeMask[result.channel])
    else $error("unselected channel converted");
  AST_MASK_HELD: assert property (busy && $past(busy) |-> $stable(activeMask))
    else $error("latched mask moved");
  AST_HOLD_BUSY: assert property (holdActive == busy)
    else $error("hold differs from busy");
  AST_INPUT_ONLY: assert property (busBitsOe == 4'h0)
    else $error("data lines driven");
endmodule // channel_sequence_select_sva

// ---- tb/channel_sequence_select_tb.sv ----
// Self-checking bench for the channel sequencer.
`timescale 1ns/1ps
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", name, exp, got); end end
module channel_sequence_select_tb;
  import channel_sequence_select_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic conversionStart_n = 1'b1;
  logic softwareSelect = 1'b0;
  logic [3:0] hwChannelPins = 4'h0;
  logic [59:0] trackLevels = {15'h7fff, 15'h4000, 15'h0001, 15'h0000};
  hostBus_type hostBus;
  logic [3:0] busBitsOut, busBitsOe, activeMask, channelMask;
  logic busy, endOfConversion_n, holdActive, resultValid, externalClockInUse;
  result_type result;
  int checks = 0;
  int miscompares = 0;
  // Clock at 50 MHz.
  always #10 clk = ~clk;
  channel_sequence_select #(.BIPOLAR(1'b1), .CONV_CYCLES(4), .EXT_CONV_EDGES(2), .EOC_CYCLES(1)) dut (
    .clk(clk), .srst(srst), .conversionStart_n(conversionStart_n), .softwareSelect(softwareSelect),
    .hwChannelPins(hwChannelPins), .hostBus(hostBus), .trackLevels(trackLevels), .busBitsOut(busBitsOut),
    .busBitsOe(busBitsOe), .busy(busy), .endOfConversion_n(endOfConversion_n), .holdActive(holdActive),
    .resultValid(resultValid), .result(result), .activeMask(activeMask), .channelMask(channelMask),
    .externalClockInUse(externalClockInUse));
  result_type resultUni;
  // A unipolar twin on the same pins runs in lockstep and shows the straight binary coding.
  channel_sequence_select #(.BIPOLAR(1'b0), .CONV_CYCLES(4), .EXT_CONV_EDGES(2), .EOC_CYCLES(1)) dutUni (
    .clk(clk), .srst(srst), .conversionStart_n(conversionStart_n), .softwareSelect(softwareSelect),
    .hwChannelPins(hwChannelPins), .hostBus(hostBus), .trackLevels(trackLevels), .busBitsOut(),
    .busBitsOe(), .busy(), .endOfConversion_n(), .holdActive(), .resultValid(), .result(resultUni),
    .activeMask(), .channelMask(), .externalClockInUse());
  host_processor_model host (.clk(clk), .hostBus(hostBus));
  // Straight code: half-step level rounded to whole steps and clamped at the top code.
  function automatic logic [13:0] straightOf(input logic [14:0] level);
    logic [15:0] s;
    s = ({1'b0, level} + 16'h1) >> 1;
    if (s > 16'h3fff) s = 16'h3fff;
    return s[13:0];
  endfunction
  // Two's complement code: straight code with the top bit flipped.
  function automatic logic [13:0] codeOf(input logic [14:0] level);
    return straightOf(level) ^ 14'h2000;
  endfunction
  task automatic pulseStart();
    @(negedge clk);
    conversionStart_n = 1'b0;
    repeat (3) @(negedge clk);
    conversionStart_n = 1'b1;
  endtask
  // Waits are bounded so a lost result shows up as a mismatch, not a hang.
  task automatic expectSeq(input logic [3:0] mask, input logic extClk);
    int n;
    for (int ch = 0; ch < 4; ch++) begin
      if (mask[ch]) begin
        n = 0;
        while (resultValid !== 1'b1 && n < 400) begin
          @(negedge clk);
          if (extClk) hwChannelPins[0] = ~hwChannelPins[0];
          n++;
        end
        `CHK("channel", ch[1:0], result.channel)
        `CHK("code", codeOf(trackLevels[ch*15 +: 15]), result.code)
        `CHK("unipolar code", straightOf(trackLevels[ch*15 +: 15]), resultUni.code)
        `CHK("latched mask", mask, activeMask)
        `CHK("clock source", extClk, externalClockInUse)
        @(negedge clk);
      end
    end
    repeat (3) @(negedge clk);
    `CHK("busy end", 1'b0, busy)
  endtask
  // Pins pick 1, 3, 4; pins move mid-run without effect.
  task automatic testPins();
    hwChannelPins = 4'b1101;
    pulseStart();
    repeat (4) @(negedge clk);
    hwChannelPins = 4'b0010;
    expectSeq(4'b1101, 1'b0);
  endtask
  // Register mode: a refused write, reuse across runs and the external clock.
  task automatic testSoftware();
    host.write(4'ha, 1'b1);
    repeat (4) @(negedge clk);
    `CHK("mask reg", 4'ha, channelMask)
    `CHK("data drive", 4'h0, busBitsOut)
    host.write(4'h5, 1'b0);
    repeat (4) @(negedge clk);
    `CHK("refused write", 4'ha, channelMask)
    softwareSelect = 1'b1;
    hwChannelPins = 4'b1100;
    pulseStart();
    expectSeq(4'ha, 1'b0);
    pulseStart();
    expectSeq(4'ha, 1'b0);
    hwChannelPins = 4'b0010;
    pulseStart();
    expectSeq(4'ha, 1'b1);
  endtask
  // An empty mask shows exactly one busy cycle and no end pulse.
  task automatic testEmpty();
    softwareSelect = 1'b0;
    hwChannelPins = 4'h0;
    pulseStart();
    repeat (3) @(negedge clk);
    `CHK("empty busy high", 1'b1, busy)
    `CHK("empty latched mask", 4'h0, activeMask)
    @(negedge clk);
    `CHK("empty busy", 1'b0, busy)
    `CHK("empty no end pulse", 1'b1, endOfConversion_n)
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    testPins();
    testSoftware();
    testEmpty();
    test_done();
  end
  // Watchdog well beyond the couple of hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule // channel_sequence_select_tb
bind channel_sequence_select channel_sequence_select_sva #(.CONV_CYCLES(CONV_CYCLES)) sva (
  .clk(clk), .srst(srst), .busy(busy), .endOfConversion_n(endOfConversion_n), .holdActive(holdActive),
  .resultValid(resultValid), .result(result), .activeMask(activeMask), .busBitsOe(busBitsOe),
  .externalClockInUse(externalClockInUse));

// ---- tb/host_processor_model.sv ----
// Host processor that writes the channel mask over the low data lines.
`timescale 1ns/1ps
module host_processor_model (
  input wire logic clk,
  output channel_sequence_select_pkg::hostBus_type hostBus
);
  import channel_sequence_select_pkg::*;
  // Idle bus: strobes high.
  initial hostBus = '{1'b1, 1'b1, 1'b1, 4'h0};
  // A low readOk keeps the read strobe low, which the device must ignore.
  task automatic write(input logic [3:0] value, input logic readOk);
    @(negedge clk);
    hostBus <= '{1'b0, readOk, 1'b0, value};
    repeat (4) @(negedge clk);
    hostBus.writeStrobe_n <= 1'b1;
    repeat (3) @(negedge clk);
    // Released lines show the inverse so stale data is never mistaken for a hold.
    hostBus <= '{1'b1, 1'b1, 1'b1, ~value};
  endtask
endmodule // host_processor_model
